// ===== logic/chi_pkg.sv
package chi_pkg;
    // Clock and speed
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam logic [24:0] CLK_HZ_W  = 25'(CLK_HZ);
    localparam logic [22:0] SPEED_MAX = 23'h7A_1200;
    localparam logic [22:0] SPEED_MIN = 23'h00_0001;
    // Offsets accepted around the current position
    localparam logic signed [33:0] COORD_MAX = 34'sh0_3FFF_FFFF;
    // Command word layout
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_AXIS_LSB = 8;
    // Mode data word layout
    localparam int MODE_EN_LSB  = 0;
    localparam int MODE_SWAP    = 4;
    // Command codes
    localparam logic [7:0] CMD_SPEED  = 8'h05;
    localparam logic [7:0] CMD_FINISH = 8'h06;
    localparam logic [7:0] CMD_CENTER = 8'h08;
    localparam logic [7:0] CMD_TURNS  = 8'h1A;
    localparam logic [7:0] CMD_MODE   = 8'h2A;
    localparam logic [7:0] CMD_CW     = 8'h64;
    localparam logic [7:0] CMD_CCW    = 8'h65;
    localparam logic [7:0] CMD_HCALC  = 8'h66;
    localparam logic [7:0] CMD_HCW    = 8'h67;
    localparam logic [7:0] CMD_HCCW   = 8'h68;
    localparam logic [7:0] CMD_STOP   = 8'h27;
    // Axis indices
    localparam logic [1:0] AX_X = 2'h0;
    localparam logic [1:0] AX_Y = 2'h1;

    typedef enum logic [1:0] {
        CHI_IDLE = 2'b00,
        CHI_RUN  = 2'b01
    } chi_fsm_t;

    typedef struct packed {
        chi_fsm_t          fsm;
        logic [3:0]        mode_en;
        logic              swap;
        logic [15:0]       turns;
        logic [22:0]       speed;
        logic [3:0][33:0]  center;
        logic [3:0][33:0]  finish;
        logic [24:0]       phase;
        logic signed [33:0] u;
        logic signed [33:0] v;
        logic signed [39:0] f;
        logic signed [33:0] fu;
        logic signed [33:0] fv;
        logic [2:0]        oct;
        logic [2:0]        soct;
        logic [2:0]        foct;
        logic              armed;
        logic [15:0]       laps;
        logic              ccw;
        logic              calc;
        logic              helix;
        logic [1:0]        hax;
        logic [1:0]        vax;
        logic [31:0]       total;
        logic [31:0]       cnt;
        logic [1:0][32:0]  hacc;
        logic [3:0]        pulse;
        logic [3:0]        dir;
        logic              done;
    } chi_state_t;

    localparam chi_state_t STATE_RST = '0;
endpackage

// ===== logic/chi_top.sv
`timescale 1ns/1ps
// Function
// - Any two of the four axes can form the arc.
// - Higher priority axis (X>Y>Z>U) goes horizontal, lower goes vertical.
// - Right and up are the positive arc directions.
// - Mode bit D4 swaps horizontal and vertical assignment.
// - CW command traces clockwise, CCW counterclockwise.
// - Finish offset of zero on both axes gives a full circle.
// - Eight octants; horizontal long in 0,3,4,7, vertical in others.
// - Short axis steps every step; long axis only when chosen.
// - Offsets up to plus or minus 1,073,741,823 are accepted.
// - Path stays within one count of the ideal circle.
// - Arc speed from 1 to 8 million pulses per second.
// - Start is origin; radius comes from the centre offset.
// - Stop in finish octant once short axis reaches finish value.
// - Stop at octant boundary when finish value is never reached.
// - Helical mode moves extra axes with the XY arc, multi-turn too.
// - Helical calculation counts arc steps; drive spreads feeds evenly.
// - Helical arc fixed to X and Y; D0-D3 enable X,Y,Z,U.
// - Turn command 1Ah loads 0 to 65,535 without axis selection.
// - Full-circle helix: turns 0 or 1 give one lap, else that many.
module chi_top (
    input  wire logic        ref_clk,        // System clock
    input  wire logic        rst,            // Async reset, high
    input  wire logic        cmd_valid,      // Command strobe
    input  wire logic [15:0] command_word,   // Axis and code
    input  wire logic [15:0] data_word_low,  // Data low half
    input  wire logic [15:0] data_word_high, // Data high half
    output logic      [3:0]  step_pulse,     // Step per axis
    output logic      [3:0]  step_dir,       // 1 = positive
    output logic             busy,           // Move running
    output logic             done            // Move ended
);

    chi_pkg::chi_state_t s;
    chi_pkg::chi_state_t n;

    logic [31:0]        data;
    logic [7:0]         code;
    logic [3:0]         axsel;
    logic               hel;
    logic [1:0]         ha;
    logic [1:0]         va;
    logic [1:0]         tmp;
    logic signed [33:0] cx;
    logic signed [33:0] cy;
    logic signed [33:0] fu0;
    logic signed [33:0] fv0;
    logic [2:0]         so0;
    logic [2:0]         fo0;
    logic               lh0;
    logic               pos0;
    logic               ahead;
    logic               full;
    logic [24:0]        ph_sum;
    logic               tick;
    logic               lh;
    logic               spos;
    logic               lpos;
    logic signed [33:0] sc;
    logic signed [33:0] lc;
    logic signed [33:0] nsc;
    logic signed [33:0] nlc;
    logic signed [33:0] nu;
    logic signed [33:0] nv;
    logic signed [33:0] fs;
    logic               lhf;
    logic               sposf;
    logic signed [33:0] nsf;
    logic signed [39:0] f1;
    logic signed [39:0] f2;
    logic               tk;
    logic [2:0]         no;
    logic               reach;
    logic               leave;
    logic               endnow;
    logic [32:0]        ha_sum;

    function automatic logic [2:0] oct_of(input logic signed [33:0] x,
                                          input logic signed [33:0] y);
        logic [33:0] ax;
        logic [33:0] ay;
        ax = x[33] ? 34'(-x) : x;
        ay = y[33] ? 34'(-y) : y;
        if (!x[33] && !y[33])
            oct_of = (ax >= ay) ? 3'h0 : 3'h1;
        else if (x[33] && !y[33])
            oct_of = (ay > ax) ? 3'h2 : 3'h3;
        else if (x[33] && y[33])
            oct_of = (ax >= ay) ? 3'h4 : 3'h5;
        else
            oct_of = (ay > ax) ? 3'h6 : 3'h7;
    endfunction

    function automatic logic long_h(input logic [2:0] o);
        long_h = (o == 3'h0) || (o == 3'h3) || (o == 3'h4) || (o == 3'h7);
    endfunction

    // Short-axis direction is the tangent of the circle around the centre
    function automatic logic short_pos(input logic lhz, input logic ccw,
                                       input logic signed [33:0] x,
                                       input logic signed [33:0] y);
        if (lhz)
            short_pos = ccw ? !x[33] : x[33];
        else
            short_pos = ccw ? y[33] : !y[33];
    endfunction

    // Circle residue after a unit step on coordinate c
    function automatic logic signed [39:0] fstep(
        input logic signed [39:0] f,
        input logic signed [33:0] c,
        input logic pos);
        logic signed [39:0] d;
        d = {{5{c[33]}}, c, 1'b0};
        fstep = pos ? f + d + 40'sh00_0000_0001 : f - d + 40'sh00_0000_0001;
    endfunction

    function automatic logic [39:0] abs40(input logic signed [39:0] x);
        abs40 = x[39] ? 40'(-x) : x;
    endfunction

    function automatic logic [1:0] low_axis(input logic [3:0] m);
        low_axis = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    endfunction

    function automatic logic signed [33:0] clamp(input logic [31:0] d);
        logic signed [33:0] x;
        x = {{2{d[31]}}, d};
        if (x > chi_pkg::COORD_MAX)
            clamp = chi_pkg::COORD_MAX;
        else if (x < -chi_pkg::COORD_MAX)
            clamp = -chi_pkg::COORD_MAX;
        else
            clamp = x;
    endfunction

    always_comb
    begin
        n      = s;
        n.pulse = '0;
        n.dir   = s.dir;
        n.done  = 1'b0;
        data  = {data_word_high, data_word_low};
        code  = command_word[chi_pkg::CMD_CODE_LSB +: 8];
        axsel = command_word[chi_pkg::CMD_AXIS_LSB +: 4];
        hel   = (code == chi_pkg::CMD_HCALC) || (code == chi_pkg::CMD_HCW)
             || (code == chi_pkg::CMD_HCCW);
        // Helical arc fixed to X/Y; otherwise two lowest enabled axes
        ha  = hel ? chi_pkg::AX_X : low_axis(s.mode_en);
        va  = hel ? chi_pkg::AX_Y
                  : low_axis(s.mode_en & ~(4'h1 << ha));
        if (s.swap)
        begin
            tmp = ha;
            ha  = va;
            va  = tmp;
        end
        else
            tmp = 2'h0;
        // Position relative to centre; start point is the origin
        cx    = s.center[ha];
        cy    = s.center[va];
        fu0   = s.finish[ha] - cx;
        fv0   = s.finish[va] - cy;
        so0   = oct_of(-cx, -cy);
        fo0   = oct_of(fu0, fv0);
        lh0   = long_h(so0);
        pos0  = short_pos(lh0, (code == chi_pkg::CMD_CCW)
                              || (code == chi_pkg::CMD_HCCW), -cx, -cy);
        ahead = (fo0 == so0) && (lh0 ? (pos0 ? fv0 > -cy : fv0 < -cy)
                                     : (pos0 ? fu0 > -cx : fu0 < -cx));
        full  = (s.finish[ha] == '0) && (s.finish[va] == '0);

        // Rate generator
        ph_sum = s.phase + 25'(s.speed);
        tick   = 1'b0;
        if (s.fsm == chi_pkg::CHI_RUN)
        begin
            if (s.calc)
                tick = 1'b1;
            else
            begin
                tick    = ph_sum >= chi_pkg::CLK_HZ_W;
                n.phase = tick ? ph_sum - chi_pkg::CLK_HZ_W : ph_sum;
            end
        end

        // One interpolation step
        lh   = long_h(s.oct);
        spos = short_pos(lh, s.ccw, s.u, s.v);
        sc   = lh ? s.v : s.u;
        lc   = lh ? s.u : s.v;
        // Long axis moves so that x*dx + y*dy stays near zero
        lpos = !(lc[33] ^ sc[33] ^ spos);
        f1   = fstep(s.f, sc, spos);
        f2   = fstep(f1, lc, lpos);
        tk   = abs40(f2) < abs40(f1);
        nsc  = spos ? sc + 34'sh1 : sc - 34'sh1;
        nlc  = tk ? (lpos ? lc + 34'sh1 : lc - 34'sh1) : lc;
        nu   = lh ? nlc : nsc;
        nv   = lh ? nsc : nlc;
        no   = oct_of(nu, nv);
        // Judged on the finish octant's short axis, so a step that lands
        // on the finish while entering that octant still ends the arc
        lhf   = long_h(s.foct);
        sposf = short_pos(lhf, s.ccw, nu, nv);
        nsf   = lhf ? nv : nu;
        fs    = lhf ? s.fv : s.fu;
        reach = (no == s.foct)
             && (sposf ? nsf >= fs : nsf <= fs);
        leave = (s.oct == s.foct) && (no != s.foct);
        endnow = s.armed && (reach || leave);
        ha_sum = '0;

        if (tick)
        begin
            n.u   = nu;
            n.v   = nv;
            n.f   = tk ? f2 : f1;
            n.oct = no;
            n.cnt = s.cnt + 32'h0000_0001;
            if ((s.oct == s.soct) && (no != s.soct))
                n.armed = 1'b1;
            if (!s.calc)
            begin
                // Short axis always, long axis only when chosen
                n.pulse[s.hax] = !lh || tk;
                n.pulse[s.vax] = lh || tk;
                n.dir[s.hax]   = lh ? lpos : spos;
                n.dir[s.vax]   = lh ? spos : lpos;
            end
            // Even spread of feed over the counted arc length
            if (s.helix && !s.calc && (s.total != '0))
            begin
                for (int k = 0; k < 2; k++)
                begin
                    if (s.mode_en[2 + k])
                    begin
                        ha_sum = s.hacc[k] + (s.finish[2 + k][33]
                               ? 33'(-s.finish[2 + k])
                               : 33'(s.finish[2 + k]));
                        if (ha_sum >= {1'b0, s.total})
                        begin
                            n.pulse[2 + k] = 1'b1;
                            n.dir[2 + k]   = !s.finish[2 + k][33];
                            ha_sum = ha_sum - {1'b0, s.total};
                        end
                        n.hacc[k] = ha_sum;
                    end
                end
            end
            if (endnow)
            begin
                if (s.laps != '0)
                begin
                    n.laps  = s.laps - 16'h0001;
                    n.armed = 1'b0;
                end
                else
                begin
                    n.fsm  = chi_pkg::CHI_IDLE;
                    n.done = 1'b1;
                    if (s.calc)
                        n.total = s.cnt + 32'h0000_0001;
                end
            end
        end

        if (cmd_valid && (s.fsm == chi_pkg::CHI_RUN)
            && (code == chi_pkg::CMD_STOP))
        begin
            n.fsm  = chi_pkg::CHI_IDLE;
            n.done = 1'b1;
        end
        // Setup is only taken while idle to keep a move self-consistent
        if (cmd_valid && (s.fsm == chi_pkg::CHI_IDLE))
        begin
            case (code)
                chi_pkg::CMD_MODE:
                begin
                    n.mode_en = data[chi_pkg::MODE_EN_LSB +: 4];
                    n.swap    = data[chi_pkg::MODE_SWAP];
                end
                chi_pkg::CMD_TURNS:
                    n.turns = data[15:0];
                chi_pkg::CMD_SPEED:
                begin
                    if (data > 32'(chi_pkg::SPEED_MAX))
                        n.speed = chi_pkg::SPEED_MAX;
                    else if (data == '0)
                        n.speed = chi_pkg::SPEED_MIN;
                    else
                        n.speed = data[22:0];
                end
                chi_pkg::CMD_CENTER:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (axsel[i])
                            n.center[i] = clamp(data);
                    end
                end
                chi_pkg::CMD_FINISH:
                begin
                    for (int i = 0; i < 4; i++)
                    begin
                        if (axsel[i])
                            n.finish[i] = clamp(data);
                    end
                end
                chi_pkg::CMD_CW, chi_pkg::CMD_CCW, chi_pkg::CMD_HCALC,
                chi_pkg::CMD_HCW, chi_pkg::CMD_HCCW:
                begin
                    n.hax   = ha;
                    n.vax   = va;
                    n.u     = -cx;
                    n.v     = -cy;
                    n.f     = '0;
                    n.fu    = fu0;
                    n.fv    = fv0;
                    n.oct   = so0;
                    n.soct  = so0;
                    n.foct  = fo0;
                    n.armed = (fo0 != so0) || ahead;
                    n.ccw   = (code == chi_pkg::CMD_CCW)
                           || (code == chi_pkg::CMD_HCCW);
                    n.calc  = (code == chi_pkg::CMD_HCALC);
                    n.helix = hel;
                    n.phase = '0;
                    n.cnt   = '0;
                    n.hacc  = '0;
                    if (!hel)
                        n.laps = '0;
                    else if (full)
                        n.laps = (s.turns == '0) ? 16'h0000
                               : s.turns - 16'h0001;
                    else
                        n.laps = s.turns;
                    // Zero radius has no path to trace
                    if ((cx == '0) && (cy == '0))
                        n.done = 1'b1;
                    else
                        n.fsm = chi_pkg::CHI_RUN;
                end
                default:
                    n.fsm = s.fsm;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s <= chi_pkg::STATE_RST;
        else
            s <= n;
    end

    assign step_pulse = s.pulse;
    assign step_dir   = s.dir;
    // Bit 0 marks the run code, so busy is a flop with no gate
    assign busy       = s.fsm[0];
    assign done       = s.done;

endmodule // chi_top

// ===== testbench/chi_motor_model.sv
`timescale 1ns/1ps
module chi_motor_model (
    input wire logic       ref_clk,    // Clock
    input wire logic       rst,        // Async reset
    input wire logic [3:0] step_pulse, // Steps
    input wire logic [3:0] step_dir,   // Directions
    output int             pos [4],    // Position per axis
    output int             cnt [4]     // Pulse count per axis
);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pos[i] <= 0;
                cnt[i] <= 0;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (step_pulse[i])
                begin
                    cnt[i] <= cnt[i] + 1;
                    pos[i] <= pos[i] + (step_dir[i] ? 1 : -1);
                end
            end
        end
    end
endmodule // chi_motor_model

// ===== testbench/chi_props.sv
`timescale 1ns/1ps
module chi_props (
    input wire logic        ref_clk,        // Clock
    input wire logic        rst,            // Async reset
    input wire logic        cmd_valid,      // Command strobe
    input wire logic [15:0] command_word,   // Axis and code
    input wire logic [15:0] data_word_low,  // Data low
    input wire logic [15:0] data_word_high, // Data high
    input wire logic [3:0]  step_pulse,     // Steps
    input wire logic [3:0]  step_dir,       // Directions
    input wire logic        busy,           // Move running
    input wire logic        done            // Move ended
);
    logic start_c;
    logic calc_c;
    logic calc_on;

    assign calc_c  = cmd_valid && !busy
                     && command_word[7:0] == chi_pkg::CMD_HCALC;
    assign start_c = cmd_valid && !busy && (command_word[7:0] inside
                     {chi_pkg::CMD_CW, chi_pkg::CMD_CCW, chi_pkg::CMD_HCALC,
                      chi_pkg::CMD_HCW, chi_pkg::CMD_HCCW});

    // Helix calculation in progress, from its start up to its done
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            calc_on <= 1'b0;
        else if (calc_c)
            calc_on <= 1'b1;
        else if (done)
            calc_on <= 1'b0;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    reset_quiet_a: assert property ($fell(rst) |-> step_pulse == 4'h0
        && step_dir == 4'h0 && !busy && !done)
        else $error("outputs not quiet after reset");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    done_idle_a: assert property (done |-> !busy)
        else $error("done while busy");
    busy_end_a: assert property ($fell(busy) |-> done)
        else $error("move ended without done");
    pulse_owned_a: assert property (|step_pulse |-> busy || done)
        else $error("step outside a move");
    start_busy_a: assert property (start_c |=> busy || done)
        else $error("start not taken");
    pulse_spacing_a: assert property (|step_pulse |=> step_pulse == 4'h0)
        else $error("steps closer than top speed allows");
    dir_hold_a: assert property (!busy && !cmd_valid |=> $stable(step_dir))
        else $error("direction moved while idle");
    calc_quiet_a: assert property (calc_on |-> step_pulse == 4'h0)
        else $error("step during helix calculation");
    calc_bound_a: assert property (calc_c |-> ##[1:1000] done)
        else $error("helix calculation did not end");
endmodule // chi_props

// ===== testbench/chi_top_tb.sv
`timescale 1ns/1ps
module chi_top_tb;
    logic        ref_clk;
    logic        rst;
    logic        cmd_valid;
    logic [15:0] command_word;
    logic [15:0] data_word_low;
    logic [15:0] data_word_high;
    logic [3:0]  step_pulse;
    logic [3:0]  step_dir;
    logic        busy;
    logic        done;
    int          pos [4];
    int          cnt [4];
    int          p0 [4];
    int          c0 [4];
    int          errors;
    int          checks;
    int          ticks;
    int          gap;
    logic [3:0]  fp;
    logic [3:0]  fd;

    chi_top uut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .command_word(command_word), .data_word_low(data_word_low),
        .data_word_high(data_word_high), .step_pulse(step_pulse),
        .step_dir(step_dir), .busy(busy), .done(done));
    chi_motor_model drv (.ref_clk(ref_clk), .rst(rst),
        .step_pulse(step_pulse), .step_dir(step_dir), .pos(pos), .cnt(cnt));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Whole plan needs about 3000 cycles
    always @(posedge ref_clk)
    begin
        ticks++;
        if (ticks == 40000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] code, input logic [3:0] ax,
                       input logic [31:0] d);
        @(posedge ref_clk);
        #2;
        cmd_valid = 1'b1;
        command_word = {4'h0, ax, code};
        {data_word_high, data_word_low} = d;
        @(posedge ref_clk);
        #2;
        cmd_valid = 1'b0;
    endtask

    // Geometry is relative to the start point, reloaded every move
    task automatic arc(input logic [3:0] ah, input logic [3:0] av,
                       input int ch, input int cv, input int fh, input int fv);
        cmd(chi_pkg::CMD_CENTER, ah, ch);
        cmd(chi_pkg::CMD_CENTER, av, cv);
        cmd(chi_pkg::CMD_FINISH, ah, fh);
        cmd(chi_pkg::CMD_FINISH, av, fv);
    endtask

    // Starts a move, notes the first step and the gap to the next
    task automatic run(input logic [7:0] code);
        int cyc;
        int t1;
        p0 = pos;
        c0 = cnt;
        cmd(code, 4'h0, 32'h0000_0000);
        fp = 4'h0;
        fd = 4'h0;
        gap = 0;
        cyc = 0;
        t1 = 0;
        while (done !== 1'b1 && cyc < 20000)
        begin
            @(posedge ref_clk);
            #1;
            cyc++;
            if (fp == 4'h0 && |step_pulse)
            begin
                fp = step_pulse;
                fd = step_dir;
                t1 = cyc;
            end
            else if (|step_pulse && gap == 0)
                gap = cyc - t1;
        end
        // The motor counts the last step one edge after done
        @(posedge ref_clk);
        #1;
        chk(cyc < 20000, 1);
    endtask

    task automatic t_circle;
        cmd(chi_pkg::CMD_MODE, 4'h0, 32'h0000_0003);
        cmd(chi_pkg::CMD_SPEED, 4'h1, 32'd8000000);
        arc(4'h1, 4'h2, -11, 0, 0, 0);
        run(chi_pkg::CMD_CW);
        chk(pos[0] - p0[0], 0);
        chk(pos[1] - p0[1], 0);
        chk(cnt[0] - c0[0], 44);
        chk(cnt[1] - c0[1], 44);
        chk({fp[1], fd[1]}, 2'b10);
        $display("t_circle finished");
    endtask

    task automatic t_dir;
        for (int i = 0; i < 2; i++)
        begin
            arc(4'h1, 4'h2, -5, 0, -5, 5);
            run(i == 1 ? chi_pkg::CMD_CCW : chi_pkg::CMD_CW);
            chk(pos[0] - p0[0], -5);
            chk(pos[1] - p0[1], 5);
            chk(cnt[0] - c0[0], i == 1 ? 5 : 15);
            chk({fp[1], fd[1]}, {1'b1, i[0]});
        end
        $display("t_dir finished");
    endtask

    task automatic t_swap;
        cmd(chi_pkg::CMD_MODE, 4'h0, 32'h0000_0013);
        arc(4'h2, 4'h1, -11, 0, 0, 0);
        run(chi_pkg::CMD_CW);
        chk({fp[0], fd[0]}, 2'b10);
        chk(pos[1] - p0[1], 0);
        chk(cnt[1] - c0[1], 44);
        $display("t_swap finished");
    endtask

    task automatic t_pair;
        cmd(chi_pkg::CMD_MODE, 4'h0, 32'h0000_000C);
        arc(4'h4, 4'h8, -11, 0, 0, 0);
        run(chi_pkg::CMD_CCW);
        chk({fp[3], fd[3]}, 2'b11);
        chk(cnt[0] - c0[0] + cnt[1] - c0[1], 0);
        chk(cnt[2] - c0[2], 44);
        chk(pos[3] - p0[3], 0);
        $display("t_pair finished");
    endtask

    task automatic t_speed;
        cmd(chi_pkg::CMD_MODE, 4'h0, 32'h0000_0003);
        cmd(chi_pkg::CMD_SPEED, 4'h1, 32'd1000000);
        arc(4'h1, 4'h2, -11, 0, 0, 0);
        run(chi_pkg::CMD_CW);
        chk(gap, 20);
        arc(4'h1, 4'h2, 0, 0, 0, 0);
        run(chi_pkg::CMD_CW);
        chk({fp, busy}, 5'h00);
        $display("t_speed finished");
    endtask

    task automatic t_stop;
        arc(4'h1, 4'h2, -11, 0, 0, 0);
        cmd(chi_pkg::CMD_CW, 4'h0, 32'h0000_0000);
        chk(busy, 1'b1);
        cmd(chi_pkg::CMD_STOP, 4'h0, 32'h0000_0000);
        chk({busy, done}, 2'b01);
        $display("t_stop finished");
    endtask

    task automatic t_helix;
        cmd(chi_pkg::CMD_MODE, 4'h0, 32'h0000_0007);
        for (int i = 0; i < 2; i++)
        begin
            cmd(chi_pkg::CMD_SPEED, 4'h1, 32'd8000000);
            cmd(chi_pkg::CMD_TURNS, 4'h0, 32'h0000_0002);
            if (i == 0)
            begin
                arc(4'h1, 4'h2, -11, 0, 0, 0);
                run(chi_pkg::CMD_HCALC);
                chk(fp, 4'h0);
            end
            arc(4'h1, 4'h2, -11, 0, 0, 0);
            cmd(chi_pkg::CMD_FINISH, 4'h4, i == 0 ? 10 : -6);
            run(i == 0 ? chi_pkg::CMD_HCW : chi_pkg::CMD_HCCW);
            chk(cnt[0] - c0[0], 88);
            chk(pos[1] - p0[1], 0);
            chk(pos[2] - p0[2], i == 0 ? 10 : -6);
            chk(cnt[2] - c0[2], i == 0 ? 10 : 6);
        end
        $display("t_helix finished");
    endtask

    initial
    begin
        errors = 0;
        checks = 0;
        ticks = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        command_word = 16'h0000;
        data_word_low = 16'h0000;
        data_word_high = 16'h0000;
        repeat (16) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        @(posedge ref_clk);
        #1;
        chk({step_pulse, step_dir, busy, done}, 10'h000);
        $display("t_reset finished");
        t_circle();
        t_dir();
        t_swap();
        t_pair();
        t_speed();
        t_stop();
        t_helix();
        tally_and_finish();
    end
endmodule // chi_top_tb

bind chi_top chi_props u_props (.ref_clk(ref_clk), .rst(rst),
    .cmd_valid(cmd_valid), .command_word(command_word),
    .data_word_low(data_word_low), .data_word_high(data_word_high),
    .step_pulse(step_pulse), .step_dir(step_dir), .busy(busy), .done(done));
